// ==== hdl/sew_slave.v ====
// Two-wire serial EEPROM bus slave: write path, addressing, staging buffer
// How it works
// - Idle bus means both lines high; transfers begin only after start.
// - Data falling while clock high is a start; device detects it.
// - Data rising while clock high is a stop; device detects it.
// - Transmitter changes data only while clock low; one bit per pulse.
// - Receiver pulls data low across the ninth clock to acknowledge.
// - Master withholds read acknowledge; device releases data line high.
// - First byte after start is control byte: type, selects, block, rw.
// - Respond only when chip-select bits equal sampled pin levels.
// - Block-select bit is address bit 16, choosing array half.
// - Last control bit one means read, zero means write.
// - After matching acknowledge, choose read or write handling by rw.
// - Write sends high then low address byte into pointer.
// - Byte write acks control, addresses, data; stop launches write.
// - No acknowledge of launching control byte while programming runs.
// - Protected write is acknowledged, not programmed, ready at once.
// - After a write the pointer holds one past the last written.
// - Partial page writes reprogram whole page with existing contents.
// - Up to 127 further bytes buffered; array programmed after stop. Code stages 16 in its FIFO and withholds ack while it is full.
// - Only low seven pointer bits increment; overflow wraps in page.
// - Page boundary wraps to start of same page.
// - Write protect sampled at stop; later changes ignored.
// - Programming cycle completes within 5 ms of stop.
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.vh"

// ============================================================
// Staging FIFO
module sew_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             mclk,
    input  wire             arst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_idx;
    reg [AW-1:0]    rd_idx;
    reg [AW:0]      count;
    wire            do_push;
    wire            do_pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = store[rd_idx];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always @(posedge mclk) begin
        if (do_push) begin
            store[wr_idx] <= in_data;
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_idx <= {AW{1'b0}};
            rd_idx <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_idx <= wr_idx + 1'b1;
            end
            if (do_pop) begin
                rd_idx <= rd_idx + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ============================================================
// Bus slave top
module sew_slave #(
    parameter [3:0]              DEV_TYPE   = 4'h5, // Arbitrary value
    parameter [`SEW_TIMER_W-1:0] TWC_CYCLES = `SEW_TWC_CYCLES
) (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire        chip_select_low_pin,
    input  wire        chip_select_high_pin,
    input  wire        wp_pin,
    output reg         mem_wr_valid,
    input  wire        mem_wr_ready,
    output reg  [16:0] mem_wr_addr,
    output reg  [7:0]  mem_wr_data,
    output reg         prog_start,
    output reg         prog_discard,
    output reg         busy,
    output reg  [16:0] mem_rd_addr,
    input  wire [7:0]  mem_rd_data
);
    localparam [3:0] S_IDLE   = 4'h0;
    localparam [3:0] S_CTRL   = 4'h1;
    localparam [3:0] S_ADDRH  = 4'h2;
    localparam [3:0] S_ADDRL  = 4'h3;
    localparam [3:0] S_WDATA  = 4'h4;
    localparam [3:0] S_RDATA  = 4'h5;
    localparam [3:0] S_IGNORE = 4'h6;

    // ========================================================
    // Input synchronisers
    reg  [1:0] scl_sync;
    reg  [1:0] sda_sync;
    reg  [1:0] wp_sync;
    reg  [1:0] csl_sync;
    reg  [1:0] csh_sync;
    reg        scl_d;
    reg        sda_d;
    wire       scl;
    wire       sda;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            wp_sync  <= 2'h0;
            csl_sync <= 2'h0;
            csh_sync <= 2'h0;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            wp_sync  <= {wp_sync[0], wp_pin};
            csl_sync <= {csl_sync[0], chip_select_low_pin};
            csh_sync <= {csh_sync[0], chip_select_high_pin};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    assign scl       = scl_sync[1];
    assign sda       = sda_sync[1];
    assign scl_rise  = scl && !scl_d;
    assign scl_fall  = !scl && scl_d;
    // Both lines share sync depth so edge order is preserved
    assign start_det = scl && scl_d && sda_d && !sda;
    assign stop_det  = scl && scl_d && !sda_d && sda;

    // ========================================================
    // Control byte match
    function ctrl_hit;
        input [7:0] b;
        input [1:0] cs;
        begin
            ctrl_hit = (b[`SEW_CB_TYPE_MSB:`SEW_CB_TYPE_LSB] == DEV_TYPE) &&
                       (b[`SEW_CB_CS_HI:`SEW_CB_CS_LO] == cs);
        end
    endfunction

    // ========================================================
    // Staging buffer between bus and array page latch
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [24:0] fifo_out_data;
    wire        fifo_pop;
    reg         push_valid;
    reg  [24:0] push_data;

    // Output stage keeps array-side outputs on flops
    assign fifo_pop = fifo_out_valid && (!mem_wr_valid || mem_wr_ready);

    sew_fifo #(
        .WIDTH (`SEW_FIFO_WIDTH),
        .DEPTH (`SEW_FIFO_DEPTH),
        .AW    (`SEW_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr  <= 17'h00000;
            mem_wr_data  <= 8'h00;
        end else if (fifo_pop) begin
            mem_wr_valid <= 1'b1;
            mem_wr_addr  <= fifo_out_data[24:8];
            mem_wr_data  <= fifo_out_data[7:0];
        end else if (mem_wr_ready) begin
            mem_wr_valid <= 1'b0;
        end
    end

    // ========================================================
    // Protocol engine
    reg [3:0]              state;
    reg [3:0]              next_state;
    reg [3:0]              bit_cnt;
    reg                    ack_done;
    reg                    master_nack;
    reg [7:0]              shreg;
    reg [7:0]              tx;
    reg [7:0]              ctrl_byte;
    reg [7:0]              launch_ctrl;
    reg [16:0]             ptr;
    reg                    wr_seen;
    reg                    drain_wait;
    reg [`SEW_TIMER_W-1:0] timer;
    wire                   hit;

    assign hit = ctrl_hit(shreg, {csh_sync[1], csl_sync[1]});

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state        <= S_IDLE;
            next_state   <= S_IDLE;
            bit_cnt      <= 4'h0;
            ack_done     <= 1'b0;
            master_nack  <= 1'b0;
            shreg        <= 8'h00;
            tx           <= 8'hff;
            ctrl_byte    <= 8'h00;
            launch_ctrl  <= 8'h00;
            ptr          <= 17'h00000;
            wr_seen      <= 1'b0;
            drain_wait   <= 1'b0;
            timer        <= {`SEW_TIMER_W{1'b0}};
            busy         <= 1'b0;
            prog_start   <= 1'b0;
            prog_discard <= 1'b0;
            push_valid   <= 1'b0;
            push_data    <= 25'h0000000;
            sda_out      <= 1'b0;
            sda_oe       <= 1'b0;
            mem_rd_addr  <= 17'h00000;
        end else begin
            prog_start  <= 1'b0;
            prog_discard <= 1'b0;
            push_valid  <= 1'b0;
            mem_rd_addr <= ptr;
            if (start_det) begin
                // Restart inside a write abandons buffered bytes
                if (wr_seen) begin
                    prog_discard <= 1'b1;
                end
                state    <= S_CTRL;
                bit_cnt  <= 4'h0;
                ack_done <= 1'b0;
                wr_seen  <= 1'b0;
                sda_oe   <= 1'b0;
            end else if (stop_det) begin
                state    <= S_IDLE;
                bit_cnt  <= 4'h0;
                ack_done <= 1'b0;
                sda_oe   <= 1'b0;
                wr_seen  <= 1'b0;
                if (wr_seen) begin
                    if (wp_sync[1]) begin
                        prog_discard <= 1'b1;
                    end else begin
                        busy        <= 1'b1;
                        drain_wait  <= 1'b1;
                        launch_ctrl <= ctrl_byte;
                    end
                end
            end else if (scl_rise && state != S_IDLE &&
                         state != S_IGNORE) begin
                if (bit_cnt == `SEW_ACK_SLOT) begin
                    ack_done <= 1'b1;
                    if (state == S_RDATA) begin
                        master_nack <= sda;
                    end
                end else begin
                    shreg   <= {shreg[6:0], sda};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall && state != S_IDLE &&
                         state != S_IGNORE) begin
                if (ack_done) begin
                    // Ninth pulse over: release, or drive the first bit of the next read byte, and move on
                    ack_done <= 1'b0;
                    bit_cnt  <= 4'h0;
                    if (state == S_RDATA && master_nack) begin
                        state  <= S_IGNORE;
                        sda_oe <= 1'b0;
                    end else if (next_state == S_RDATA) begin
                        state  <= S_RDATA;
                        tx     <= mem_rd_data;
                        sda_oe <= ~mem_rd_data[7];
                    end else begin
                        state  <= next_state;
                        sda_oe <= 1'b0;
                    end
                end else if (bit_cnt == `SEW_ACK_SLOT) begin
                    case (state)
                        S_CTRL: begin
                            ctrl_byte <= shreg;
                            // Writes cannot be staged while programming
                            if (hit && !(busy && (shreg == launch_ctrl ||
                                !shreg[`SEW_CB_RW]))) begin
                                sda_oe  <= 1'b1;
                                ptr[16] <= shreg[`SEW_CB_BLK];
                                if (shreg[`SEW_CB_RW]) begin
                                    next_state <= S_RDATA;
                                end else begin
                                    next_state <= S_ADDRH;
                                end
                            end else begin
                                sda_oe     <= 1'b0;
                                next_state <= S_IGNORE;
                            end
                        end
                        S_ADDRH: begin
                            sda_oe      <= 1'b1;
                            ptr[15:8]   <= shreg;
                            next_state  <= S_ADDRL;
                        end
                        S_ADDRL: begin
                            sda_oe      <= 1'b1;
                            ptr[7:0]    <= shreg;
                            next_state  <= S_WDATA;
                        end
                        S_WDATA: begin
                            // Full buffer refuses the byte by withholding ack
                            if (fifo_in_ready) begin
                                sda_oe     <= 1'b1;
                                push_valid <= 1'b1;
                                push_data  <= {ptr, shreg};
                                wr_seen    <= 1'b1;
                                ptr[`SEW_PAGE_MSB:0] <=
                                    ptr[`SEW_PAGE_MSB:0] + 7'h01;
                                next_state <= S_WDATA;
                            end else begin
                                sda_oe     <= 1'b0;
                                next_state <= S_IGNORE;
                            end
                        end
                        S_RDATA: begin
                            // Line released so master can ack or not
                            sda_oe     <= 1'b0;
                            ptr[15:0]  <= ptr[15:0] + 16'h0001;
                            next_state <= S_RDATA;
                        end
                        default: begin
                            sda_oe     <= 1'b0;
                            next_state <= S_IGNORE;
                        end
                    endcase
                end else if (state == S_RDATA) begin
                    tx     <= {tx[6:0], 1'b1};
                    sda_oe <= ~tx[6];
                end
            end

            // Programming starts once every staged byte reached the latch;
            // the array refreshes unwritten page bytes itself
            if (drain_wait && !fifo_out_valid && !mem_wr_valid &&
                !push_valid) begin
                drain_wait <= 1'b0;
                prog_start <= 1'b1;
                timer      <= TWC_CYCLES;
            end else if (busy && !drain_wait) begin
                if (timer <= {{(`SEW_TIMER_W-1){1'b0}}, 1'b1}) begin
                    busy  <= 1'b0;
                    timer <= {`SEW_TIMER_W{1'b0}};
                end else begin
                    timer <= timer - {{(`SEW_TIMER_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== hdl/sew_map.vh ====
// Constants for the serial EEPROM bus slave write front end
`ifndef SEW_MAP_VH
`define SEW_MAP_VH

// ============================================================
// Control byte field positions
`define SEW_CB_RW        0
`define SEW_CB_BLK       1
`define SEW_CB_CS_LO     2
`define SEW_CB_CS_HI     3
`define SEW_CB_TYPE_LSB  4
`define SEW_CB_TYPE_MSB  7

// ============================================================
// Byte framing
`define SEW_ACK_SLOT     4'h8
`define SEW_PAGE_MSB     6

// ============================================================
// Write staging buffer
`define SEW_FIFO_WIDTH   25
`define SEW_FIFO_DEPTH   16
`define SEW_FIFO_AW      4

// ============================================================
// Programming cycle time
`define SEW_TWC_MS       5
`define SEW_MCLK_KHZ     125000
`define SEW_TWC_CYCLES   20'h98968
`define SEW_TIMER_W      20

`endif

// ==== verification/sew_slave_monitor.sv ====
// Assertion checker on the bus slave ports
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.vh"
// ========
// Checker
module sew_slave_monitor #(
    parameter [3:0]              DEV_TYPE   = 4'h5,
    parameter [`SEW_TIMER_W-1:0] TWC_CYCLES = `SEW_TWC_CYCLES
) (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        chip_select_low_pin,
    input wire logic        chip_select_high_pin,
    input wire logic        wp_pin,
    input wire logic        mem_wr_valid,
    input wire logic        mem_wr_ready,
    input wire logic [16:0] mem_wr_addr,
    input wire logic [7:0]  mem_wr_data,
    input wire logic        prog_start,
    input wire logic        prog_discard,
    input wire logic        busy,
    input wire logic [16:0] mem_rd_addr,
    input wire logic [7:0]  mem_rd_data
);
    logic [`SEW_TIMER_W:0] cnt;
    // Cycles since launch; cleared while idle
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) cnt <= '0;
        else cnt <= (prog_start || !busy) ? '0 : cnt + 1'b1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_low; sda_out == 1'b0; endproperty
    a_low: assert property (p_low) else $error("sda_out high");
    property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
    a_rise: assert property (p_rise) else $error("oe rose, scl high");
    property p_hold; sda_oe && scl_in |=> sda_oe; endproperty
    a_hold: assert property (p_hold) else $error("oe dropped");
    property p_stage; mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
        && $stable(mem_wr_addr) && $stable(mem_wr_data); endproperty
    a_stage: assert property (p_stage) else $error("byte lost");
    property p_pulse; prog_start |=> !prog_start; endproperty
    a_pulse: assert property (p_pulse) else $error("long start");
    // Array programmed only while busy and with no byte held at the latch port
    property p_launch; prog_start |-> busy && !mem_wr_valid; endproperty
    a_launch: assert property (p_launch) else $error("bad launch");
    property p_drop; prog_discard |=> !prog_discard && !busy; endproperty
    a_drop: assert property (p_drop) else $error("bad discard");
    property p_twc; $fell(busy) |-> cnt >= TWC_CYCLES - 2
        && cnt <= TWC_CYCLES + 1; endproperty
    a_twc: assert property (p_twc) else $error("busy length");
endmodule
bind sew_slave sew_slave_monitor #(
    .DEV_TYPE(DEV_TYPE), .TWC_CYCLES(TWC_CYCLES)) u_mon (
    .mclk(mclk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp_pin),
    .chip_select_low_pin(chip_select_low_pin),
    .chip_select_high_pin(chip_select_high_pin),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .prog_start(prog_start), .prog_discard(prog_discard), .busy(busy),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
`default_nettype wire

// ==== verification/sew_master_model.sv ====
// Two-wire bus master model for the bench
`timescale 1ns/1ps
`default_nettype none
// ========
// Bus master
module sew_master_model (
    output var logic scl,
    output var logic sda_m,
    input wire logic sda
);
    int unsigned q = 40; // Quarter bus period; raise it for a slow master
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Offset by 1 ns so edges never meet the bench clock
    task automatic start_c;
        #1 sda_m = 1'b1;
        #q scl = 1'b1;
        #q sda_m = 1'b0;
        #q scl = 1'b0;
        #q;
    endtask
    task automatic stop_c;
        #1 sda_m = 1'b0;
        #q scl = 1'b1;
        #q sda_m = 1'b1;
        #(2 * q);
    endtask
    task automatic clk_bit(input logic b, output logic s);
        sda_m = b;
        #q scl = 1'b1;
        #q s = sda;
        #q scl = 1'b0;
        #q;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(last, s);
    endtask
endmodule
`default_nettype wire

// ==== verification/serial_eeprom_bus_slave_write_bench.sv ====
// Self-checking bench for the bus slave write front end
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.vh"
// ========
// Bench top
module serial_eeprom_bus_slave_write_bench;
    localparam [`SEW_TIMER_W-1:0] TWC = 20'd400;
    localparam [3:0]              TYP = 4'h5; // Arbitrary type code
    logic        mclk = 1'b0, arst_n = 1'b0, cs_lo = 1'b0, cs_hi = 1'b1;
    logic        wp = 1'b0, rdy = 1'b1, scl, sda_m, sda_out, sda_oe;
    logic        wr_valid, prog_start, prog_discard, busy;
    logic [7:0]  rd_data = 8'h00, wr_data;
    logic [16:0] wr_addr, rd_addr;
    wire         sda;
    int          fails = 0, n_checks = 0, n_prog = 0, n_disc = 0;
    logic [24:0] got_q[$];
    assign sda = sda_m & ~sda_oe; // Pull-up unless a side pulls low
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        rd_data <= rd_addr[7:0] ^ 8'h3c;
        if (prog_start) n_prog++;
        if (prog_discard) n_disc++;
        if (wr_valid && rdy) got_q.push_back({wr_addr, wr_data});
    end
    sew_slave #(.DEV_TYPE(TYP), .TWC_CYCLES(TWC)) DUT (
        .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp),
        .chip_select_low_pin(cs_lo), .chip_select_high_pin(cs_hi),
        .mem_wr_valid(wr_valid), .mem_wr_ready(rdy),
        .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
        .prog_start(prog_start), .prog_discard(prog_discard),
        .busy(busy), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data));
    sew_master_model M (.scl(scl), .sda_m(sda_m), .sda(sda));
    // ========
    // Helpers
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [24:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 2000 && busy !== lvl; i++) @(posedge mclk);
        if (busy !== lvl) begin
            chk("busy_wait", lvl, busy);
            report_and_stop;
        end
    endtask
    function automatic logic [7:0] ctl(input logic [1:0] cs, input logic b,
                                       input logic r);
        return {TYP, cs, b, r};
    endfunction
    task automatic wr_hdr(input logic [7:0] c, input logic [15:0] a,
                          output logic [2:0] k);
        M.start_c;
        M.send_byte(c, k[2]);
        M.send_byte(a[15:8], k[1]);
        M.send_byte(a[7:0], k[0]);
    endtask
    // ========
    // Scenarios
    task automatic t_byte_write;
        logic [2:0] k;
        logic       a, p;
        int         n0;
        n0 = n_prog;
        got_q.delete();
        wr_hdr(ctl(2'b10, 1'b1, 1'b0), 16'h1234, k);
        M.send_byte(8'ha5, a);
        M.stop_c;
        chk("ack", 25'hf, {k, a});
        chk("busy", 25'h1, busy);
        // Protect raised after the stop must not cancel the cycle
        @(posedge mclk) wp <= 1'b1;
        M.start_c;
        M.send_byte(ctl(2'b10, 1'b1, 1'b0), p);
        M.stop_c;
        chk("poll", 25'h0, p);
        wait_busy(1'b0);
        @(posedge mclk) wp <= 1'b0;
        chk("launch", n0 + 1, n_prog);
        chk("byte", {17'h11234, 8'ha5}, got_q[0]);
        chk("ptr", 17'h11235, rd_addr);
        $display("test byte_write done");
    endtask
    task automatic t_protect;
        logic [2:0] k;
        logic       a;
        int         n0;
        n0 = n_disc;
        @(posedge mclk) wp <= 1'b1;
        wr_hdr(ctl(2'b10, 1'b0, 1'b0), 16'h0010, k);
        M.send_byte(8'h3c, a);
        M.stop_c;
        @(posedge mclk) wp <= 1'b0;
        chk("ack", 25'hf, {k, a});
        chk("discard", n0 + 1, n_disc);
        chk("busy", 25'h0, busy);
        $display("test protect done");
    endtask
    // Stalled latch fills the buffer; pointer wraps inside the page
    task automatic t_page;
        logic [2:0]  k;
        logic [19:0] a;
        logic [6:0]  lo;
        int          j;
        got_q.delete();
        @(posedge mclk) rdy <= 1'b0;
        wr_hdr(ctl(2'b10, 1'b1, 1'b0), 16'h207e, k);
        for (int i = 0; i < 20; i++) M.send_byte(8'h40 + 8'(i), a[i]);
        chk("ack", 25'h7, k);
        chk("fill", 25'hffff, a[15:0]);
        chk("full", 25'h0, a[19]);
        @(posedge mclk) rdy <= 1'b1;
        M.stop_c;
        for (j = 0; j < 200 && got_q.size() < 16; j++) @(posedge mclk);
        if (got_q.size() < 16) begin
            chk("drain", 25'd16, got_q.size());
            report_and_stop;
        end
        wait_busy(1'b0);
        for (int i = 0; i < 16; i++) begin
            lo = 7'h7e + 7'(i);
            chk("page", {10'h240, lo, 8'h40 + 8'(i)}, got_q[i]);
        end
        $display("test page done");
    endtask
    task automatic t_read;
        logic [2:0] k;
        logic       a;
        logic [7:0] b0, b1;
        wr_hdr(ctl(2'b10, 1'b0, 1'b0), 16'h00ff, k);
        M.start_c;
        M.send_byte(ctl(2'b10, 1'b0, 1'b1), a);
        M.recv_byte(1'b0, b0);
        M.recv_byte(1'b1, b1);
        chk("release", 25'h0, sda_oe);
        M.stop_c;
        chk("ack", 25'hf, {k, a});
        chk("rd0", 25'hc3, b0);
        chk("rd1", 25'h3c, b1);
        $display("test read done");
    endtask
    task automatic t_select;
        logic [5:0] c;
        logic       a, a2;
        logic [7:0] b;
        @(posedge mclk) begin
            cs_hi <= 1'b0;
            cs_lo <= 1'b1;
        end
        for (int i = 0; i < 5; i++) begin
            // Realign so bus edges stay clear of the bench clock
            @(posedge mclk);
            c = (i < 4) ? {TYP, 2'(i)} : {TYP ^ 4'h1, 2'b01};
            M.start_c;
            M.send_byte({c, 2'b01}, a);
            chk("select", c == {TYP, 2'b01}, a);
            if (a === 1'b1) begin
                M.recv_byte(1'b1, b);
            end else begin
                M.send_byte({TYP, 4'b0101}, a2);
                chk("ignore", 25'h0, a2);
            end
            M.stop_c;
        end
        $display("test select done");
    endtask
    // ========
    // Sequence
    initial begin
        #400000;
        chk("timeout", 25'h0, 25'h1);
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_byte_write;
        t_protect;
        t_page;
        t_read;
        t_select;
        report_and_stop;
    end
endmodule
`default_nettype wire
